// ### src/lbrp_top.sv
// Local bus cycle sequencer and request pin front end
// Functional notes
// - DMA requests are level sensitive and pass a synchroniser first.
// - Non-maskable interrupt raises an interrupt of type two.
// - Rising edge of NMI synchronised, latched, served at instruction boundary.
// - No control input can mask the non-maskable interrupt.
// - Maskable request inputs are active high and synchronised.
// - Pins two and three can become active-low acknowledge outputs.
// - Each maskable input is edge or level triggered, individually.
// - Address phase drives top four address bits on upper pins.
// - Later phases drive origin status low for CPU, high for DMA.
// - Later phases hold the other three status pins low.
// - Upper and address-only outputs float in hold and reset.
// - Address-only outputs hold valid address through all phases.
// - Low pins carry address in first phase, data afterwards.
// - Multiplexed pins float during hold or reset.
// - Compatible mode keeps refresh indicator high.
// - Enhanced mode drives refresh indicator low for refresh cycles.
// - Refresh indicator floats during hold and reset in both modes.
`timescale 1ns/100ps
`include "lbrp_consts.svh"
module lbrp_top (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        mode_strap,
	input  wire logic        bus_hold,
	input  wire logic        cyc_start,
	input  wire logic [19:0] cyc_addr,
	input  wire logic        cyc_write,
	input  wire logic [7:0]  cyc_wdata,
	input  wire logic        cyc_dma,
	input  wire logic        cyc_refresh,
	input  wire logic        cyc_ready,
	input  wire logic        dma_req_ch0,
	input  wire logic        dma_req_ch1,
	input  wire logic        nmi_pin,
	input  wire logic        mask_req_0,
	input  wire logic        mask_req_1,
	input  wire logic        mask_req_2,
	input  wire logic        mask_req_3,
	input  wire logic [3:0]  trig_level,
	input  wire logic [1:0]  ack_out_en,
	input  wire logic        slave_mode,
	input  wire logic [3:0]  mask_clr,
	input  wire logic        nmi_clr,
	input  wire logic        instr_boundary,
	input  wire logic [1:0]  ack_pulse,
	input  wire logic [7:0]  ad_in,
	output logic [3:0]       addr_top_o,
	output logic             addr_top_oe,
	output logic [7:0]       addr_mid_o,
	output logic             addr_mid_oe,
	output logic [7:0]       ad_o,
	output logic             ad_oe,
	output logic             refresh_cycle_n,
	output logic             refresh_oe,
	output logic             ack_out_0_n,
	output logic             ack_out_1_n,
	output logic [1:0]       ack_oe,
	output logic [1:0]       dma_req_sync,
	output logic [3:0]       mask_pend,
	output logic             nmi_take,
	output logic [7:0]       nmi_type,
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	output logic             enhanced_mode,
	output logic             cyc_busy
);
	lbrp_pkg::lbrp_phase_t phase_ff;
	lbrp_pkg::lbrp_phase_t nxt_phase;
	logic [19:0] addr_ff;
	logic [7:0]  wdata_ff;
	logic        write_ff;
	logic        dma_ff;
	logic        refresh_ff;
	logic        float_now;
	logic        enhanced;
	logic [6:0]  sync_lvl;
	logic [3:0]  mask_prev_ff;
	logic [3:0]  mask_pend_ff;
	logic        nmi_prev_ff;
	logic        nmi_pend_ff;
	logic        nmi_take_ff;
	logic [7:0]  nmi_type_ff;
	logic [3:0]  addr_top_ff;
	logic        addr_top_oe_ff;
	logic [7:0]  addr_mid_ff;
	logic        addr_mid_oe_ff;
	logic [7:0]  ad_ff;
	logic        ad_oe_ff;
	logic        rcyc_n_ff;
	logic        rcyc_oe_ff;
	logic [1:0]  ack_n_ff;
	logic [1:0]  ack_oe_ff;
	logic [1:0]  dma_ff2;
	logic [7:0]  rd_data_ff;
	logic        rd_valid_ff;
	logic        busy_ff;
	logic [3:0]  mask_raw;
	logic [3:0]  is_input;

	lbrp_sync_if sif ();

	assign sif.raw  = {nmi_pin, mask_req_3, mask_req_2, mask_req_1, mask_req_0,
	                   dma_req_ch1, dma_req_ch0};
	assign sync_lvl = sif.synced;

	lbrp_sync u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.sif    (sif)
	);

	lbrp_strap u_strap (
		.clk        (clk),
		.arst_n     (arst_n),
		.mode_strap (mode_strap),
		.enhanced   (enhanced)
	);

	// Reset floats the pins through the flop resets; hold floats them here
	assign float_now = bus_hold;
	assign mask_raw  = sync_lvl[5:2];
	assign is_input  = {~ack_out_en[1], ~ack_out_en[0], 2'b11};

	always_comb begin
		nxt_phase = phase_ff;
		unique case (phase_ff)
			lbrp_pkg::LBRP_IDLE: begin
				if (cyc_start && !bus_hold)
					nxt_phase = lbrp_pkg::LBRP_ADDR;
			end
			lbrp_pkg::LBRP_ADDR:  nxt_phase = lbrp_pkg::LBRP_SECND;
			lbrp_pkg::LBRP_SECND: nxt_phase = lbrp_pkg::LBRP_THIRD;
			lbrp_pkg::LBRP_THIRD,
			lbrp_pkg::LBRP_WAIT: begin
				nxt_phase = cyc_ready ? lbrp_pkg::LBRP_FINAL : lbrp_pkg::LBRP_WAIT;
			end
			lbrp_pkg::LBRP_FINAL: nxt_phase = lbrp_pkg::LBRP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			phase_ff <= lbrp_pkg::LBRP_IDLE;
		else
			phase_ff <= nxt_phase;
	end

	// Cycle attributes are frozen at start so pins stay stable all cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_ff    <= 20'h00000;
			wdata_ff   <= 8'h00;
			write_ff   <= 1'b0;
			dma_ff     <= 1'b0;
			refresh_ff <= 1'b0;
		end else if (phase_ff == lbrp_pkg::LBRP_IDLE && cyc_start && !bus_hold) begin
			addr_ff    <= cyc_addr;
			wdata_ff   <= cyc_wdata;
			write_ff   <= cyc_write;
			dma_ff     <= cyc_dma;
			refresh_ff <= cyc_refresh;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			busy_ff <= 1'b0;
		else
			busy_ff <= (nxt_phase != lbrp_pkg::LBRP_IDLE);
	end

	// Upper address/status pins, registered from the next phase so they change with it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_top_ff    <= 4'h0;
			addr_top_oe_ff <= 1'b0;
		end else begin
			addr_top_oe_ff <= !float_now && nxt_phase != lbrp_pkg::LBRP_IDLE;
			if (nxt_phase == lbrp_pkg::LBRP_ADDR) begin
				addr_top_ff <= cyc_addr[`LBRP_AW-1:`LBRP_ADDR_HI_LSB];
			end else begin
				addr_top_ff <= {dma_ff, `LBRP_ZERO_STATUS};
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_mid_ff    <= 8'h00;
			addr_mid_oe_ff <= 1'b0;
		end else begin
			addr_mid_oe_ff <= !float_now && nxt_phase != lbrp_pkg::LBRP_IDLE;
			if (nxt_phase == lbrp_pkg::LBRP_ADDR)
				addr_mid_ff <= cyc_addr[`LBRP_ADDR_HI_LSB-1:`LBRP_ADDR_MID_LSB];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ad_ff    <= 8'h00;
			ad_oe_ff <= 1'b0;
		end else if (float_now || nxt_phase == lbrp_pkg::LBRP_IDLE) begin
			ad_oe_ff <= 1'b0;
		end else if (nxt_phase == lbrp_pkg::LBRP_ADDR) begin
			ad_ff    <= cyc_addr[`LBRP_ADDR_MID_LSB-1:0];
			ad_oe_ff <= 1'b1;
		end else begin
			// Reads leave the pins released so the far side can drive them
			ad_ff    <= wdata_ff;
			ad_oe_ff <= write_ff;
		end
	end

	// Read data captured at the final phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= phase_ff == lbrp_pkg::LBRP_FINAL && !write_ff;
			if (phase_ff == lbrp_pkg::LBRP_FINAL && !write_ff)
				rd_data_ff <= ad_in;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rcyc_n_ff  <= 1'b1;
			rcyc_oe_ff <= 1'b0;
		end else begin
			rcyc_oe_ff <= !float_now;
			if (!enhanced) begin
				rcyc_n_ff <= 1'b1;
			end else begin
				rcyc_n_ff <= !(nxt_phase != lbrp_pkg::LBRP_IDLE &&
				             (nxt_phase == lbrp_pkg::LBRP_ADDR ? cyc_refresh : refresh_ff));
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			dma_ff2 <= 2'h0;
		else
			dma_ff2 <= sync_lvl[1:0];
	end

	// Maskable requests; set wins over clear so no edge is lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_prev_ff <= 4'h0;
			mask_pend_ff <= 4'h0;
		end else begin
			mask_prev_ff <= mask_raw;
			for (int i = 0; i < 4; i++) begin
				if (slave_mode || !is_input[i])
					mask_pend_ff[i] <= 1'b0;
				else if (trig_level[i])
					mask_pend_ff[i] <= mask_raw[i];
				else if (mask_raw[i] && !mask_prev_ff[i])
					mask_pend_ff[i] <= 1'b1;
				else if (mask_clr[i])
					mask_pend_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_n_ff  <= 2'b11;
			ack_oe_ff <= 2'b00;
		end else begin
			ack_oe_ff <= ack_out_en & {2{!slave_mode}};
			ack_n_ff  <= ~(ack_pulse & ack_out_en);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nmi_prev_ff <= 1'b0;
			nmi_pend_ff <= 1'b0;
			nmi_take_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= sync_lvl[6];
			if (sync_lvl[6] && !nmi_prev_ff)
				nmi_pend_ff <= 1'b1;
			else if (nmi_clr || (nmi_pend_ff && instr_boundary))
				nmi_pend_ff <= 1'b0;
			nmi_take_ff <= nmi_pend_ff && instr_boundary;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			nmi_type_ff <= `LBRP_NMI_TYPE;
		else
			nmi_type_ff <= `LBRP_NMI_TYPE;
	end

	assign addr_top_o      = addr_top_ff;
	assign addr_top_oe     = addr_top_oe_ff;
	assign addr_mid_o      = addr_mid_ff;
	assign addr_mid_oe     = addr_mid_oe_ff;
	assign ad_o            = ad_ff;
	assign ad_oe           = ad_oe_ff;
	assign refresh_cycle_n = rcyc_n_ff;
	assign refresh_oe      = rcyc_oe_ff;
	assign ack_out_0_n     = ack_n_ff[0];
	assign ack_out_1_n     = ack_n_ff[1];
	assign ack_oe          = ack_oe_ff;
	assign dma_req_sync    = dma_ff2;
	assign mask_pend       = mask_pend_ff;
	assign nmi_take        = nmi_take_ff;
	assign nmi_type        = nmi_type_ff;
	assign rd_data         = rd_data_ff;
	assign rd_valid        = rd_valid_ff;
	assign enhanced_mode   = enhanced;
	assign cyc_busy        = busy_ff;
endmodule

// ### inc/lbrp_consts.svh
// Constants for the local bus and request pin front end
`ifndef LBRP_CONSTS_SVH
`define LBRP_CONSTS_SVH
`define LBRP_NMI_TYPE        8'h02
`define LBRP_STRAP_DELAY     3'h4
`define LBRP_AW              20
`define LBRP_ORIGIN_BIT      3
`define LBRP_ADDR_HI_LSB     16
`define LBRP_ADDR_MID_LSB    8
`define LBRP_ZERO_STATUS     3'h0
`endif

// ### inc/lbrp_pkg.sv
// Types for the local bus and request pin front end
package lbrp_pkg;
	typedef enum logic [5:0] {
		LBRP_IDLE  = 6'h01,
		LBRP_ADDR  = 6'h02,
		LBRP_SECND = 6'h04,
		LBRP_THIRD = 6'h08,
		LBRP_WAIT  = 6'h10,
		LBRP_FINAL = 6'h20
	} lbrp_phase_t;
endpackage

// ### inc/lbrp_sync_if.sv
// Interface carrying raw request pins into the synchroniser and levels back
`timescale 1ns/100ps
interface lbrp_sync_if;
	logic [6:0] raw;
	logic [6:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface

// ### src/lbrp_sync.sv
// Two-flop synchronisers for every request input
`timescale 1ns/100ps
module lbrp_sync (
	input  wire logic clk,
	input  wire logic arst_n,
	lbrp_sync_if.sync sif
);
	logic [6:0] meta_ff;
	logic [6:0] sync_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_bit
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= sif.raw[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	assign sif.synced = sync_ff;
endmodule

// ### src/lbrp_strap.sv
// Mode strap capture: high at reset release, low four clocks later
`timescale 1ns/100ps
`include "lbrp_consts.svh"
module lbrp_strap (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic mode_strap,
	output logic      enhanced
);
	logic [2:0] cnt_ff;
	logic       first_ff;
	logic       done_ff;
	logic       enh_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff   <= 3'h0;
			first_ff <= 1'b0;
			done_ff  <= 1'b0;
			enh_ff   <= 1'b0;
		end else if (!done_ff) begin
			if (cnt_ff == 3'h0)
				first_ff <= mode_strap;
			if (cnt_ff == `LBRP_STRAP_DELAY) begin
				enh_ff  <= first_ff & ~mode_strap;
				done_ff <= 1'b1;
			end
			cnt_ff <= cnt_ff + 3'h1;
		end
	end

	assign enhanced = enh_ff;
endmodule

// ### verif/lbrp_properties.sv
// Port-level assertions for the local bus front end
`timescale 1ns/100ps
`include "lbrp_consts.svh"
module lbrp_properties (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        bus_hold,
	input wire logic [19:0] cyc_addr,
	input wire logic        cyc_dma,
	input wire logic        dma_req_ch0,
	input wire logic        dma_req_ch1,
	input wire logic        instr_boundary,
	input wire logic [3:0]  addr_top_o,
	input wire logic        addr_top_oe,
	input wire logic [7:0]  addr_mid_o,
	input wire logic        addr_mid_oe,
	input wire logic [7:0]  ad_o,
	input wire logic        ad_oe,
	input wire logic        refresh_cycle_n,
	input wire logic        refresh_oe,
	input wire logic [1:0]  dma_req_sync,
	input wire logic        nmi_take,
	input wire logic [7:0]  nmi_type,
	input wire logic        enhanced_mode,
	input wire logic        cyc_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sync_lat_a: assert property (
		dma_req_sync == {$past(dma_req_ch1, 3), $past(dma_req_ch0, 3)})
		else $error("dma request sync latency wrong");
	nmi_cause_a: assert property (
		nmi_take |-> $past(instr_boundary) && nmi_type == `LBRP_NMI_TYPE)
		else $error("nmi taken without boundary or wrong type");
	addr_phase_a: assert property (
		$rose(cyc_busy) |-> ad_oe && addr_top_oe && {addr_top_o, addr_mid_o, ad_o} == $past(cyc_addr))
		else $error("address phase pins wrong");
	cyc_status_a: assert property (
		$rose(cyc_busy) |=> addr_top_o == {$past(cyc_dma, 2), 3'h0})
		else $error("cycle status pins wrong");
	mid_hold_a: assert property (
		cyc_busy && $past(cyc_busy) |-> $stable(addr_mid_o) && addr_mid_oe)
		else $error("address-only bus changed in cycle");
	phase_len_a: assert property (
		$rose(cyc_busy) |-> cyc_busy [*4])
		else $error("bus cycle too short");
	hold_float_a: assert property (
		bus_hold |=> !(addr_top_oe || addr_mid_oe || ad_oe || refresh_oe))
		else $error("output driven during hold");
	compat_refresh_a: assert property (
		!enhanced_mode && refresh_oe |-> refresh_cycle_n)
		else $error("refresh low in compatible mode");
	cover property ($rose(cyc_busy) ##1 addr_top_o[3]);
	cover property (nmi_take);
	cover property (enhanced_mode && !refresh_cycle_n);
endmodule
bind lbrp_top lbrp_properties chk_u (
	.clk             (clk),
	.arst_n          (arst_n),
	.bus_hold        (bus_hold),
	.cyc_addr        (cyc_addr),
	.cyc_dma         (cyc_dma),
	.dma_req_ch0     (dma_req_ch0),
	.dma_req_ch1     (dma_req_ch1),
	.instr_boundary  (instr_boundary),
	.addr_top_o      (addr_top_o),
	.addr_top_oe     (addr_top_oe),
	.addr_mid_o      (addr_mid_o),
	.addr_mid_oe     (addr_mid_oe),
	.ad_o            (ad_o),
	.ad_oe           (ad_oe),
	.refresh_cycle_n (refresh_cycle_n),
	.refresh_oe      (refresh_oe),
	.dma_req_sync    (dma_req_sync),
	.nmi_take        (nmi_take),
	.nmi_type        (nmi_type),
	.enhanced_mode   (enhanced_mode),
	.cyc_busy        (cyc_busy)
);

// ### verif/lbrp_mem_model.sv
// Memory or I/O device answering local bus cycles
`timescale 1ns/100ps
module lbrp_mem_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       cyc_busy,
	input  wire logic       ad_oe,
	input  wire logic [7:0] addr_mid_o,
	input  wire logic [1:0] waits,
	output logic            cyc_ready,
	output logic [7:0]      ad_in
);
	logic [3:0] cnt_ff;
	logic [7:0] pat_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 4'h0;
			pat_ff <= 8'h3c;
		end else begin
			cnt_ff <= cyc_busy ? cnt_ff + 4'h1 : 4'h0;
			pat_ff <= ~pat_ff + 8'h01;
		end
	end
	// Slow answers insert waits after the third phase
	assign cyc_ready = cyc_busy && (cnt_ff >= 4'h2 + {2'h0, waits});
	// Released bus in a cycle answers addr_mid_o ^ 8'ha5; otherwise a changing pattern
	assign ad_in = (cyc_busy && !ad_oe) ? (addr_mid_o ^ 8'ha5) : pat_ff;
endmodule

// ### verif/tb_local_bus_and_request_pins.sv
// Self-checking bench for the local bus and request pin front end
`timescale 1ns/100ps
module tb_local_bus_and_request_pins;
	logic        clk, arst_n, mode_strap, bus_hold, cyc_start, cyc_write, cyc_dma, cyc_refresh;
	logic        cyc_ready, dma_req_ch0, dma_req_ch1, nmi_pin, nmi_clr, instr_boundary;
	logic        slave_mode, mask_req_0, mask_req_1, mask_req_2, mask_req_3, enh;
	logic        addr_top_oe, addr_mid_oe, ad_oe, refresh_cycle_n, refresh_oe, ack_out_0_n;
	logic        ack_out_1_n, nmi_take, rd_valid, enhanced_mode, cyc_busy;
	logic [19:0] cyc_addr;
	logic [7:0]  cyc_wdata, ad_in, v, addr_mid_o, ad_o, nmi_type, rd_data;
	logic [3:0]  trig_level, mask_clr, addr_top_o, mask_pend;
	logic [1:0]  ack_out_en, ack_pulse, waits, ack_oe, dma_req_sync;
	int          miscompares, checks, i, k;
	lbrp_top dut_u (.*);
	lbrp_mem_model mem_u (.*);
	always #2.5 clk = ~clk;
	task summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [19:0] a);
		return a[15:8] ^ 8'ha5;
	endfunction
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task set_pins(input logic [5:0] p);
		{dma_req_ch1, dma_req_ch0, mask_req_3, mask_req_2, mask_req_1, mask_req_0} <= p;
	endtask
	// strap high at release, then low or high
	task do_reset(input logic en);
		@(posedge clk);
		arst_n <= 1'b0;
		mode_strap <= 1'b1;
		tick(8);
		arst_n <= 1'b1;
		tick(2);
		mode_strap <= !en;
		tick(6);
		enh = en;
		#1 chk(enhanced_mode, en);
	endtask
	task run_cycle(input logic [19:0] a, input logic [2:0] f);
		logic [7:0] wd;
		wd = 8'($urandom);
		@(posedge clk);
		cyc_start <= 1'b1;
		cyc_addr <= a;
		{cyc_dma, cyc_refresh, cyc_write} <= f;
		cyc_wdata <= wd;
		waits <= 2'($urandom);
		tick(1);
		cyc_start <= 1'b0;
		tick(1);
		#1 chk({ad_oe, f[0] ? ad_o : 8'h0}, {f[0], f[0] ? wd : 8'h0});
		chk(addr_top_o, {f[2], 3'h0});
		chk(refresh_cycle_n, !(f[1] && enh));
		for (k = 0; k < 12 && cyc_busy === 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (cyc_busy !== 1'b0) begin
			miscompares++;
			summarize;
		end
		chk(rd_valid, !f[0]);
		if (!f[0])
			chk(rd_data, exp_rd(a));
	endtask
	initial begin
		{clk, arst_n, bus_hold, cyc_start, cyc_write, cyc_dma, cyc_refresh, cyc_addr} = '0;
		{dma_req_ch0, dma_req_ch1, nmi_pin, nmi_clr, instr_boundary, slave_mode} = '0;
		{mask_req_0, mask_req_1, mask_req_2, mask_req_3, trig_level, mask_clr} = '0;
		{cyc_wdata, ack_out_en, ack_pulse, waits, enh} = '0;
		mode_strap = 1'b1;
		void'($urandom(26197));
		do_reset(1'b1);
		for (i = 0; i < 8; i++) begin
			v = 8'($urandom);
			if (i < 2)
				v[2:0] = i ? 3'b001 : 3'b110;
			run_cycle(20'($urandom), v[2:0]);
		end
		@(posedge clk);
		bus_hold <= 1'b1;
		cyc_start <= 1'b1;
		tick(1);
		cyc_start <= 1'b0;
		tick(2);
		#1 chk({cyc_busy, addr_top_oe, addr_mid_oe, ad_oe, refresh_oe}, 20'h0);
		@(posedge clk);
		bus_hold <= 1'b0;
		for (i = 0; i < 4; i++) begin
			v = i ? 8'($urandom) : 8'h3f;
			@(posedge clk);
			set_pins(v[5:0]);
			trig_level <= 4'hf;
			tick(3);
			#1 chk(dma_req_sync, v[5:4]);
			chk(mask_pend, v[3:0]);
		end
		@(posedge clk);
		set_pins(6'h00);
		trig_level <= 4'hc;
		mask_clr <= 4'hf;
		tick(4);
		mask_clr <= 4'h0;
		set_pins(6'h0f);
		tick(4);
		#1 chk(mask_pend, 4'hf);
		@(posedge clk);
		mask_clr <= 4'hf;
		@(posedge clk);
		mask_clr <= 4'h0;
		#1 chk(mask_pend, 4'hc);
		@(posedge clk);
		slave_mode <= 1'b1;
		tick(2);
		#1 chk(mask_pend, 4'h0);
		@(posedge clk);
		nmi_pin <= 1'b1;
		tick(2);
		nmi_pin <= 1'b0;
		tick(4);
		instr_boundary <= 1'b1;
		tick(1);
		instr_boundary <= 1'b0;
		#1 chk({nmi_take, nmi_type}, {1'b1, 8'h02});
		@(posedge clk);
		nmi_clr <= 1'b1;
		slave_mode <= 1'b0;
		ack_out_en <= 2'h3;
		@(posedge clk);
		nmi_clr <= 1'b0;
		ack_pulse <= 2'h2;
		@(posedge clk);
		ack_pulse <= 2'h0;
		#1 chk({ack_oe, ack_out_1_n, ack_out_0_n}, 4'hd);
		tick(1);
		#1 chk({ack_oe, ack_out_1_n, ack_out_0_n}, 4'hf);
		@(posedge clk);
		set_pins(6'h00);
		ack_pulse <= 2'h1;
		@(posedge clk);
		ack_pulse <= 2'h0;
		#1 chk({ack_oe, ack_out_1_n, ack_out_0_n}, 4'he);
		tick(4);
		do_reset(1'b0);
		run_cycle(20'($urandom), 3'b010);
		run_cycle(20'($urandom), 3'b011);
		summarize;
	end
endmodule
